// >>> dv/mbc_hold_master.sv
// Model of the other local bus master that asks for the bus.
// Assumes the bench drives want just after a clock edge.
`timescale 1ns/100ps
module mbc_hold_master (
	// Clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// Control
	input  wire logic want,
	output logic      hold_req
);
	// Launched from clk, so no synchroniser is needed at the block
	always_ff @(posedge clk) begin
		if (!resetn) begin
			hold_req <= 1'h0;
		end else begin
			hold_req <= want;
		end
	end
endmodule : mbc_hold_master

// >>> dv/tb_top.sv
// Self-checking bench for the minimum-mode bus control block.
// Assumes ready and the hold request are synchronous to clk.
`timescale 1ns/100ps
module tb_top;
	import mbc_pkg::*;
	logic      clk = 1'h0;
	logic      resetn = 1'h0;
	logic      mode = 1'h1;
	logic      ready = 1'h1;
	logic      want = 1'h0;
	logic      cyc_valid = 1'h0;
	mbc_req_t  cyc_req = '0;
	mbc_qevt_t q_evt = '0;
	logic      hold_req, cyc_done, addr_latch, int_ack_strobe_n_n, qs_hi, qs_lo, hold_ack, bus_float;
	mbc_pins_t pins;
	int        errors = 0;
	int        checks_done = 0;

	mbc_hold_master mbc_hold_master_i (.clk(clk), .resetn(resetn), .want(want),
		.hold_req(hold_req));
	mbc_bus_ctrl mbc_bus_ctrl_i (.clk(clk), .resetn(resetn), .min_max_select(mode),
		.ready(ready), .hold_req(hold_req), .cyc_valid(cyc_valid), .cyc_req(cyc_req),
		.q_evt(q_evt), .cyc_done(cyc_done), .pins(pins), .addr_latch(addr_latch),
		.int_ack_strobe_n(int_ack_strobe_n_n), .queue_status_hi(qs_hi), .queue_status_lo(qs_lo),
		.bus_hold_ack(hold_ack), .bus_float(bus_float));

	always #2 clk = ~clk;

	task automatic tick(int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic cmp(logic [7:0] got, logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	task automatic results;
		$display("errors=%0d checks_done=%0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : results

	task automatic queue_seq;
		logic [2:0] ev [5] = '{3'h0, 3'h4, 3'h1, 3'h2, 3'h5};
		logic [1:0] code [5] = '{MBC_QS_NOP, MBC_QS_FIRST, MBC_QS_FLUSH, MBC_QS_SUBSQ,
			MBC_QS_FLUSH};
		foreach (ev[i]) begin
			q_evt = ev[i];
			tick();
			cmp({qs_hi, qs_lo}, code[i]);
		end
		q_evt = '0;
	endtask : queue_seq

	// Ends in T4 so that a following call with slow low runs back to back
	task automatic run_cyc(logic m, logic w, logic ia, logic slow);
		int n;
		n = 0;
		if (slow) begin
			ready = 1'h0;
			tick(3);
		end
		cyc_req = '{mem: m, write: w, int_ack: ia};
		cyc_valid = 1'h1;
		while (addr_latch !== 1'h1 && n < 10) begin
			tick();
			n++;
		end
		cyc_valid = 1'h0;
		cmp(addr_latch, 1'h1);
		cmp({pins.mem_io, pins.xcvr_direction, pins.mem_io_oe}, {m, w, 1'h1});
		tick();
		n = 0;
		while (cyc_done !== 1'h1 && n < 20) begin
			cmp({pins.write_n, int_ack_strobe_n_n, addr_latch}, {!w, !ia, 1'h0});
			cmp(pins.xcvr_enable_n, (n == 0) && !w);
			if (n == 2) ready = 1'h1;
			tick();
			n++;
		end
		cmp(n == 2, !slow);
		// Read enable still stands in T4, write enable has ended
		cmp({pins.write_n, int_ack_strobe_n_n, pins.xcvr_enable_n}, {1'h1, 1'h1, w});
	endtask : run_cyc

	task automatic hold_seq;
		int n;
		n = 0;
		tick();
		want = 1'h1;
		while (hold_ack !== 1'h1 && n < 10) begin
			tick();
			n++;
		end
		cmp(8'(n), 8'h2);
		cmp(pins, 8'h2a);
		cmp({bus_float, int_ack_strobe_n_n, addr_latch}, 3'h6);
		q_evt = '{first: 1'h1, subsq: 1'h0, flush: 1'h0};
		tick();
		q_evt = '0;
		cmp({qs_hi, qs_lo}, MBC_QS_FIRST);
		want = 1'h0;
		n = 0;
		while (hold_ack !== 1'h0 && n < 10) begin
			tick();
			n++;
		end
		cmp(8'(n), 8'h2);
		cmp(pins, 8'h2a);
		run_cyc(1'h1, 1'h0, 1'h0, 1'h0);
	endtask : hold_seq

	// Outside minimum mode no cycle may start
	task automatic mode_seq;
		tick();
		mode = 1'h0;
		tick(3);
		cyc_valid = 1'h1;
		repeat (6) begin
			tick();
			cmp(addr_latch, 1'h0);
		end
		cyc_valid = 1'h0;
		mode = 1'h1;
		tick(3);
	endtask : mode_seq

	initial begin
		tick(4);
		resetn = 1'h1;
		queue_seq();
		run_cyc(1'h1, 1'h1, 1'h0, 1'h0);
		run_cyc(1'h0, 1'h0, 1'h0, 1'h1);
		run_cyc(1'h0, 1'h0, 1'h1, 1'h0);
		run_cyc(1'h1, 1'h1, 1'h0, 1'h1);
		hold_seq();
		mode_seq();
		results();
	end

	// Whole run needs some 60 cycles
	initial begin
		#4000;
		errors++;
		results();
	end
endmodule : tb_top

// >>> rtl/mbc_bus_ctrl.sv
// Minimum-mode bus control: T-state sequencer, strobes, transceiver control,
// queue status and the hold handshake. Assumes the core offers cycles on
// cyc_valid/cyc_req and queue events on q_evt, on the same clock.
// Operation
// - Queue status codes 00/01/10/11 as defined
// - Status shown the cycle after operation
// - Queue status always driven, even held
// - Minimum-mode functions when select is high
// - Select high memory, valid T4 to T4
// - Select floats weak zero during hold
// - Write strobe low in T2, T3, waits
// - Write, direction, enable float weak one
// - Acknowledge strobe low T2, T3, waits
// - Latch pulse high in every T1
// - Direction high transmit, timed like select
// - Read enable from T2 middle to T4
// - Write enable from T2 start to T4; ended here at the start of T4
// - Acknowledge hold in T4 or T1; taken here in T4 or TI
// - Float bus with acknowledge same cycle
// - Drop acknowledge when request low
`timescale 1ns/100ps
module mbc_bus_ctrl
	import mbc_pkg::*;
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	// Straps and pins
	input  wire logic             min_max_select,
	input  wire logic             ready,
	input  wire logic             hold_req,
	// Core side
	input  wire logic             cyc_valid,
	input  wire mbc_pkg::mbc_req_t cyc_req,
	input  wire mbc_pkg::mbc_qevt_t q_evt,
	output logic                  cyc_done,
	// Pins
	output mbc_pkg::mbc_pins_t    pins,
	output logic                  addr_latch,
	output logic                  int_ack_strobe_n,
	output logic                  queue_status_hi,
	output logic                  queue_status_lo,
	output logic                  bus_hold_ack,
	output logic                  bus_float
);
	import mbc_pkg::*;

	mbc_state_t state_q, state_d;
	mbc_req_t   cur_q;
	logic       ready_s, mode_s;
	logic       wait_state;
	logic       mio_q, wr_n_q, dir_q, den_n_q;
	logic       drive_q;

	// Ready and the strap come from pins; hold is synchronous to our clock
	mbc_sync u_rdy (.clk(clk), .resetn(resetn), .d(ready), .q(ready_s));
	mbc_sync u_mode (.clk(clk), .resetn(resetn), .d(min_max_select), .q(mode_s));

	function automatic logic [1:0] qs_code(input mbc_qevt_t e);
		if (e.flush)
			return MBC_QS_FLUSH;
		else if (e.first)
			return MBC_QS_FIRST;
		else if (e.subsq)
			return MBC_QS_SUBSQ;
		else
			return MBC_QS_NOP;
	endfunction : qs_code

	// Hold is taken only at a cycle boundary, never mid-cycle
	wire boundary = (state_q == MBC_T4) || (state_q == MBC_TI);
	wire grant    = hold_req && boundary && !bus_hold_ack;
	wire start    = cyc_valid && mode_s && !hold_req && !bus_hold_ack;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			MBC_TI: if (start) state_d = MBC_T1;
			MBC_T1: state_d = MBC_T2;
			MBC_T2: state_d = MBC_T3;
			MBC_T3: state_d = ready_s ? MBC_T4 : MBC_TW;
			MBC_TW: state_d = ready_s ? MBC_T4 : MBC_TW;
			MBC_T4: state_d = (start && !hold_req) ? MBC_T1 : MBC_TI;
			default: state_d = MBC_TI;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn)
			state_q <= MBC_TI;
		else
			state_q <= state_d;
	end

	always_ff @(posedge clk) begin
		if (!resetn)
			cur_q <= '0;
		else if (state_d == MBC_T1 && state_q != MBC_T1)
			cur_q <= cyc_req;
	end

	assign wait_state = (state_q == MBC_TW);

	// Strobes, registered from next state so pins change with the state
	wire in_t23w = (state_d == MBC_T2) || (state_d == MBC_T3) || (state_d == MBC_TW);
	always_ff @(posedge clk) begin
		if (!resetn) begin
			addr_latch       <= 1'b0;
			int_ack_strobe_n <= 1'b1;
			cyc_done         <= 1'b0;
		end else begin
			addr_latch       <= (state_d == MBC_T1);
			int_ack_strobe_n <= !(in_t23w && cur_q.int_ack);
			cyc_done         <= (state_d == MBC_T4);
		end
	end

	// Enable window: write from T2 start, read from the cycle after T2
	// (half-cycle points rounded to the next edge), read through T4, write until T4 starts
	wire den_write = in_t23w && cur_q.write;
	wire den_read  = ((state_d == MBC_T3) || (state_d == MBC_TW) || (state_d == MBC_T4)) &&
	                 !cur_q.write && !(state_q == MBC_T4);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			mio_q   <= MBC_RST_MIO;
			wr_n_q  <= MBC_RST_WR_N;
			dir_q   <= MBC_RST_DT;
			den_n_q <= MBC_RST_DEN_N;
		end else if (grant || bus_hold_ack) begin
			mio_q   <= 1'b0;
			wr_n_q  <= 1'b1;
			dir_q   <= 1'b1;
			den_n_q <= 1'b1;
		end else begin
			if (start && boundary) begin
				mio_q <= cyc_req.mem;
				dir_q <= cyc_req.write;
			end
			wr_n_q  <= !(in_t23w && cur_q.write);
			den_n_q <= !(den_write || den_read);
		end
	end

	// One enable for all four pins: they float and return together,
	// and each field has a single driving process
	assign pins = '{
		mem_io:            mio_q,
		mem_io_oe:         drive_q,
		write_n:           wr_n_q,
		write_n_oe:        drive_q,
		xcvr_direction:    dir_q,
		xcvr_direction_oe: drive_q,
		xcvr_enable_n:     den_n_q,
		xcvr_enable_n_oe:  drive_q
	};

	// Hold handshake; the enables fall with the acknowledge
	always_ff @(posedge clk) begin
		if (!resetn) begin
			bus_hold_ack <= 1'b0;
			bus_float    <= 1'b0;
			drive_q      <= 1'b1;
		end else if (grant) begin
			bus_hold_ack <= 1'b1;
			bus_float    <= 1'b1;
			drive_q      <= 1'b0;
		end else if (bus_hold_ack && !hold_req) begin
			bus_hold_ack <= 1'b0;
		end else if (!bus_hold_ack && bus_float && start) begin
			// Re-drive only once a new cycle is wanted
			bus_float <= 1'b0;
			drive_q   <= 1'b1;
		end
	end

	// Queue status one cycle after the event, never floated
	always_ff @(posedge clk) begin
		if (!resetn) begin
			queue_status_hi <= 1'b0;
			queue_status_lo <= 1'b0;
		end else begin
			{queue_status_hi, queue_status_lo} <= qs_code(q_evt);
		end
	end

	chk_qs_follows: assert property (@(posedge clk) disable iff (!resetn)
		1 |=> {queue_status_hi, queue_status_lo} == qs_code($past(q_evt)))
		else $error("queue status not one cycle after event");
	chk_ale_t1: assert property (@(posedge clk) disable iff (!resetn)
		(state_q == MBC_T1) |-> addr_latch)
		else $error("latch pulse missing in T1");
	chk_wr_window: assert property (@(posedge clk) disable iff (!resetn)
		(state_q == MBC_T2 && cur_q.write && !bus_hold_ack) |-> !pins.write_n)
		else $error("write strobe not low in T2");
	chk_int_ack_strobe_n_window: assert property (@(posedge clk) disable iff (!resetn)
		(state_q == MBC_T2 || state_q == MBC_T3 || wait_state) && cur_q.int_ack
		|-> !int_ack_strobe_n)
		else $error("acknowledge strobe not low in its window");
	chk_seq_order: assert property (@(posedge clk) disable iff (!resetn)
		(state_q == MBC_T1) |=> (state_q == MBC_T2) ##1 (state_q == MBC_T3))
		else $error("T1 not followed by T2 T3");
	chk_hold_ack: assert property (@(posedge clk) disable iff (!resetn)
		$rose(bus_hold_ack) |-> $past(state_q == MBC_T4 || state_q == MBC_TI))
		else $error("hold acknowledged outside a boundary");
	chk_float_with: assert property (@(posedge clk) disable iff (!resetn)
		$rose(bus_hold_ack) |-> !pins.mem_io_oe && !pins.write_n_oe && bus_float)
		else $error("bus not floated with acknowledge");
	chk_hold_drop: assert property (@(posedge clk) disable iff (!resetn)
		(bus_hold_ack && !hold_req) |=> !bus_hold_ack)
		else $error("acknowledge not dropped");
	chk_float_level: assert property (@(posedge clk) disable iff (!resetn)
		bus_hold_ack |-> !pins.mem_io && pins.write_n && pins.xcvr_enable_n &&
			pins.xcvr_direction)
		else $error("weak levels wrong during hold");
	chk_select_stable: assert property (@(posedge clk) disable iff (!resetn)
		(state_q == MBC_T2 || state_q == MBC_T3 || wait_state || state_q == MBC_T4)
		|-> $stable(pins.mem_io) && $stable(pins.xcvr_direction))
		else $error("select or direction moved inside a cycle");
	chk_enable_start: assert property (@(posedge clk) disable iff (!resetn)
		(state_q == MBC_T2) |-> (pins.xcvr_enable_n == !cur_q.write))
		else $error("transceiver enable wrong in T2");
	chk_enable_end: assert property (@(posedge clk) disable iff (!resetn)
		(state_q == MBC_T4) |-> (pins.xcvr_enable_n == cur_q.write))
		else $error("transceiver enable wrong in T4");
	chk_held_idle: assert property (@(posedge clk) disable iff (!resetn)
		bus_hold_ack |-> (state_q == MBC_TI))
		else $error("bus cycle running while held");
endmodule : mbc_bus_ctrl

// >>> rtl/mbc_pkg.sv
// Package for the minimum-mode bus control block: states, codes, cycle kinds.
// Assumes one processor clock; half-clock events are modelled at full-cycle grain.
package mbc_pkg;

	// Bus state sequence, Gray coded around T1-T2-T3-T4 and back to T1
	typedef enum logic [2:0] {
		MBC_TI = 3'h0,
		MBC_T1 = 3'h1,
		MBC_T2 = 3'h3,
		MBC_T3 = 3'h7,
		MBC_TW = 3'h6,
		MBC_T4 = 3'h5
	} mbc_state_t;

	// Queue status codes
	localparam logic [1:0] MBC_QS_NOP   = 2'h0;
	localparam logic [1:0] MBC_QS_FIRST = 2'h1;
	localparam logic [1:0] MBC_QS_FLUSH = 2'h2;
	localparam logic [1:0] MBC_QS_SUBSQ = 2'h3;

	// Reset levels of the control pins
	localparam logic MBC_RST_MIO   = 1'b0;
	localparam logic MBC_RST_WR_N  = 1'b1;
	localparam logic MBC_RST_DT    = 1'b1;
	localparam logic MBC_RST_DEN_N = 1'b1;

	// Requested bus cycle from the core
	typedef struct packed {
		logic mem;
		logic write;
		logic int_ack;
	} mbc_req_t;

	// Driven pin group, each with its output enable
	typedef struct packed {
		logic mem_io;
		logic mem_io_oe;
		logic write_n;
		logic write_n_oe;
		logic xcvr_direction;
		logic xcvr_direction_oe;
		logic xcvr_enable_n;
		logic xcvr_enable_n_oe;
	} mbc_pins_t;

	// Queue event from the prefetch logic
	typedef struct packed {
		logic first;
		logic subsq;
		logic flush;
	} mbc_qevt_t;

endpackage : mbc_pkg

// >>> rtl/mbc_sync.sv
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the input is a plain level; no filtering is done.
`timescale 1ns/100ps
module mbc_sync (
	// Clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// Level
	input  wire logic d,
	output logic      q
);
	logic meta_q;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			meta_q <= 1'b0;
			q      <= 1'b0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule : mbc_sync
